// [shared/acomm_params.svh]
`ifndef ACOMM_PARAMS_SVH
`define ACOMM_PARAMS_SVH

// ----------------------------------------------------------------
// Selection and bus
// ----------------------------------------------------------------
`define ACOMM_SEL_ADDR     8'h69
`define ACOMM_FLOAT        8'hff
`define ACOMM_INP_IDLE     8'h00

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define ACOMM_IFL_RING     0
`define ACOMM_IFL_DSR      1
`define ACOMM_IFL_CARR     2
`define ACOMM_IFL_SUPRX    3
`define ACOMM_IFL_NOTBUSY  6
`define ACOMM_OFL_RTS      0
`define ACOMM_OFL_DTR      1
`define ACOMM_OFL_SUPTX    2
`define ACOMM_OFL_BRK      3
`define ACOMM_OFL_RST      4'h0

// ----------------------------------------------------------------
// Interrupt, timing and FIFO size
// ----------------------------------------------------------------
`define ACOMM_INT_LEVEL    3'h6
`define ACOMM_INT_NONE     3'h0
`define ACOMM_CLK_NS       8
`define ACOMM_BIT_NS       128
`define ACOMM_BIT_CYC      ((`ACOMM_BIT_NS) / (`ACOMM_CLK_NS))
`define ACOMM_LAST_BIT     4'h9
`define ACOMM_FIFO_W       8
`define ACOMM_FIFO_D       16

`endif

// [shared/acomm_pkg.sv]
package acomm_pkg;

  // Transmit sequencer states, one-hot
  typedef enum logic [4:0] {
    ACOMM_IDLE  = 5'h01,
    ACOMM_WCTS  = 5'h02,
    ACOMM_FETCH = 5'h04,
    ACOMM_PUSH  = 5'h08,
    ACOMM_DRAIN = 5'h10
  } acomm_fetch_t;

  // Serializer states, one-hot
  typedef enum logic [1:0] {
    ACOMM_SER_IDLE  = 2'h1,
    ACOMM_SER_SHIFT = 2'h2
  } acomm_ser_t;

endpackage

// [hw/acomm_tx_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "acomm_params.svh"

// ----------------------------------------------------------------
// Byte FIFO between fetch and serializer
// ----------------------------------------------------------------
module acomm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic         i_clk_en,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          push = i_in_valid & o_in_ready;
  wire          pop  = o_out_valid & i_out_ready;

  // Extra pointer bit tells full from empty
  assign o_out_valid = (wr_q != rd_q);
  assign o_in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign o_out_data  = mem_q[rd_q[AW-1:0]];

  // Storage holds no reset; only pointers matter
  always_ff @(posedge i_clock)
  begin
    if (i_clk_en && push)
      mem_q[wr_q[AW-1:0]] <= i_in_data;
  end

  // Flush drops queued bytes on abort
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (i_flush)
      begin
        wr_q <= '0;
        rd_q <= '0;
      end
      else
      begin
        if (push)
          wr_q <= wr_q + 1'b1;
        if (pop)
          rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// Asynchronous transmit controller
// ----------------------------------------------------------------
module acomm_tx_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  input  wire logic        i_sel_strobe,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_init,
  input  wire logic        i_device_clear_command,
  input  wire logic        i_write_line_output_flags,
  input  wire logic [7:0]  i_ofl_data,
  input  wire logic        i_read_line_input_flags,
  input  wire logic        i_read_input_port,
  output logic [7:0]       o_io_data,
  input  wire logic        i_transmit_command,
  input  wire logic [15:0] i_start_addr,
  input  wire logic [15:0] i_term_addr,
  input  wire logic [7:0]  i_term_char,
  output logic             o_mem_req,
  output logic [15:0]      o_mem_addr,
  input  wire logic        i_mem_ack,
  input  wire logic [7:0]  i_mem_data,
  input  wire logic        i_ring,
  input  wire logic        i_dsr,
  input  wire logic        i_carrier,
  input  wire logic        i_sup_rx,
  input  wire logic        i_cts,
  output logic             o_rts,
  output logic             o_dtr,
  output logic             o_sup_tx,
  output logic             o_break,
  output logic             o_txd,
  output logic             o_int_req,
  output logic [2:0]       o_int_level
);
  acomm_pkg::acomm_fetch_t st_q;
  acomm_pkg::acomm_ser_t   ser_q;
  logic        selected_q;
  logic [3:0]  ofl_q;
  logic        not_busy_q;
  logic        rts_q;
  logic [7:0]  io_data_q;
  logic [15:0] cur_q;
  logic [7:0]  byte_q;
  logic        mem_req_q;
  logic        int_q;
  logic [2:0]  int_lvl_q;
  logic        txd_q;
  logic [7:0]  shift_q;
  logic [3:0]  bits_q;
  logic [7:0]  baud_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // INIT is a broadcast; other commands need the select latch
  wire sel_hit   = (i_io_addr & `ACOMM_SEL_ADDR) == `ACOMM_SEL_ADDR;
  wire abort     = i_init | (i_device_clear_command & selected_q);
  wire ofl_we    = i_write_line_output_flags & selected_q & ~i_init;
  // A transmit while busy is ignored, so the running frame is not disturbed
  wire start     = i_transmit_command & selected_q & not_busy_q & ~abort;
  wire is_last   = (cur_q == i_term_addr) || (byte_q == i_term_char);
  wire push_ok   = (st_q == acomm_pkg::ACOMM_PUSH) & fifo_in_ready;
  wire ser_idle  = (ser_q == acomm_pkg::ACOMM_SER_IDLE);
  wire fifo_pop  = ser_idle & fifo_out_valid & i_cts & ~abort;
  wire bit_end   = (baud_q == 8'(`ACOMM_BIT_CYC - 1));
  wire done      = (st_q == acomm_pkg::ACOMM_DRAIN) & ~fifo_out_valid & ser_idle;
  wire [7:0] line_input_flags = (8'(i_ring) << `ACOMM_IFL_RING)
                 | (8'(i_dsr) << `ACOMM_IFL_DSR)
                 | (8'(i_carrier) << `ACOMM_IFL_CARR)
                 | (8'(i_sup_rx) << `ACOMM_IFL_SUPRX)
                 | (8'(not_busy_q) << `ACOMM_IFL_NOTBUSY);
  // Set beats clear: an abort in the start cycle leaves it idle
  wire not_busy_d = (abort | done) ? 1'b1 : (start ? 1'b0 : not_busy_q);
  wire [3:0] ofl_d = i_init ? `ACOMM_OFL_RST
                   : (ofl_we ? i_ofl_data[3:0] : ofl_q);
  wire rts_d = ofl_d[`ACOMM_OFL_RTS] | ~not_busy_d;

  // ----------------------------------------------------------------
  // Host-facing registers
  // ----------------------------------------------------------------
  // Unselected reads model the pulled-up open bus
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      selected_q <= 1'b0;
      ofl_q      <= `ACOMM_OFL_RST;
      not_busy_q <= 1'b1;
      rts_q      <= 1'b0;
      io_data_q  <= `ACOMM_FLOAT;
      int_q      <= 1'b1;
      int_lvl_q  <= `ACOMM_INT_LEVEL;
    end
    else if (i_clk_en)
    begin
      if (i_init)
        selected_q <= 1'b0;
      else if (i_sel_strobe)
        selected_q <= sel_hit;
      ofl_q      <= ofl_d;
      not_busy_q <= not_busy_d;
      rts_q      <= rts_d;
      int_q      <= not_busy_d;
      int_lvl_q  <= not_busy_d ? `ACOMM_INT_LEVEL : `ACOMM_INT_NONE;
      if (i_read_line_input_flags || i_read_input_port)
        io_data_q <= !selected_q ? `ACOMM_FLOAT
                   : (i_read_line_input_flags ? line_input_flags : `ACOMM_INP_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Buffer fetch sequencer
  // ----------------------------------------------------------------
  // Fetch is held off by CTS so no byte is read before the grant
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q      <= acomm_pkg::ACOMM_IDLE;
      cur_q     <= '0;
      byte_q    <= '0;
      mem_req_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (abort)
      begin
        st_q      <= acomm_pkg::ACOMM_IDLE;
        mem_req_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          acomm_pkg::ACOMM_IDLE:
            if (start)
              st_q <= acomm_pkg::ACOMM_WCTS;
          acomm_pkg::ACOMM_WCTS:
            if (i_cts)
            begin
              cur_q <= i_start_addr;
              st_q  <= acomm_pkg::ACOMM_FETCH;
            end
          acomm_pkg::ACOMM_FETCH:
            if (mem_req_q && i_mem_ack)
            begin
              mem_req_q <= 1'b0;
              byte_q    <= i_mem_data;
              st_q      <= acomm_pkg::ACOMM_PUSH;
            end
            else
              mem_req_q <= i_cts;
          acomm_pkg::ACOMM_PUSH:
            if (push_ok)
            begin
              if (is_last)
                st_q <= acomm_pkg::ACOMM_DRAIN;
              else
              begin
                cur_q <= cur_q + 16'h0001;
                st_q  <= acomm_pkg::ACOMM_FETCH;
              end
            end
          acomm_pkg::ACOMM_DRAIN:
            if (done)
              st_q <= acomm_pkg::ACOMM_IDLE;
          default:
            st_q <= acomm_pkg::ACOMM_IDLE;
        endcase
      end
    end
  end

  acomm_fifo #(
    .W (`ACOMM_FIFO_W),
    .D (`ACOMM_FIFO_D)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_resetn    (i_resetn),
    .i_clk_en    (i_clk_en),
    .i_flush     (abort),
    .i_in_valid  (st_q == acomm_pkg::ACOMM_PUSH),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (byte_q),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Serializer
  // ----------------------------------------------------------------
  // Abort forces mark level so a cleared line never rests at space
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ser_q   <= acomm_pkg::ACOMM_SER_IDLE;
      txd_q   <= 1'b1;
      shift_q <= '0;
      bits_q  <= '0;
      baud_q  <= '0;
    end
    else if (i_clk_en)
    begin
      if (abort)
      begin
        ser_q <= acomm_pkg::ACOMM_SER_IDLE;
        txd_q <= 1'b1;
      end
      else
      begin
        case (ser_q)
          acomm_pkg::ACOMM_SER_IDLE:
          begin
            txd_q <= 1'b1;
            if (fifo_pop)
            begin
              txd_q   <= 1'b0;
              shift_q <= fifo_out_data;
              bits_q  <= '0;
              baud_q  <= '0;
              ser_q   <= acomm_pkg::ACOMM_SER_SHIFT;
            end
          end
          acomm_pkg::ACOMM_SER_SHIFT:
            if (!bit_end)
              baud_q <= baud_q + 8'h01;
            else
            begin
              baud_q <= '0;
              if (bits_q == `ACOMM_LAST_BIT)
                ser_q <= acomm_pkg::ACOMM_SER_IDLE;
              else
              begin
                txd_q   <= (bits_q == `ACOMM_LAST_BIT - 4'h1) | shift_q[0];
                shift_q <= {1'b1, shift_q[7:1]};
                bits_q  <= bits_q + 4'h1;
              end
            end
          default:
            ser_q <= acomm_pkg::ACOMM_SER_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_io_data   = io_data_q;
  assign o_mem_req   = mem_req_q;
  assign o_mem_addr  = cur_q;
  assign o_rts       = rts_q;
  assign o_dtr       = ofl_q[`ACOMM_OFL_DTR];
  assign o_sup_tx    = ofl_q[`ACOMM_OFL_SUPTX];
  assign o_break     = ofl_q[`ACOMM_OFL_BRK];
  assign o_txd       = txd_q;
  assign o_int_req   = int_q;
  assign o_int_level = int_lvl_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_unsel_float: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && i_read_line_input_flags && !selected_q) |=> (o_io_data == `ACOMM_FLOAT))
    else $error("Unselected read did not float");
  a_sel_decode: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && i_sel_strobe && !i_init && !sel_hit) |=> !selected_q)
    else $error("Selected by wrong address");
  a_init_clears: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && i_init) |=> (!selected_q && !o_break && !o_dtr && !o_sup_tx))
    else $error("Initialize did not clear state");
  a_clear_idle: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && abort) |=> (o_txd && ser_idle))
    else $error("Line not at stop level after clear");
  a_flag_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && i_read_line_input_flags && selected_q)
      |=> (o_io_data[3:0] == {$past(i_sup_rx), $past(i_carrier), $past(i_dsr), $past(i_ring)}))
    else $error("Input flag bits misreported");
  a_device_clear_command_keeps: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && i_device_clear_command && !i_init && !ofl_we) |=> $stable(ofl_q))
    else $error("Device clear changed output flags");
  a_start_busy: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && start) |=> (!not_busy_q && o_rts && st_q == acomm_pkg::ACOMM_WCTS))
    else $error("Transmit did not go busy");
  a_cts_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (!i_cts && ser_idle) |=> ser_idle)
    else $error("Character started without CTS");
  a_term_stop: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && !abort && push_ok && is_last)
      |=> (st_q == acomm_pkg::ACOMM_DRAIN && $stable(cur_q)))
    else $error("Current address ran past terminator");
  a_abort_idle: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && abort) |=> (not_busy_q && !fifo_out_valid && o_rts == ofl_q[`ACOMM_OFL_RTS]))
    else $error("Abort left transmission running");
  // Sequencer at rest means the channel is not busy; checked against the sequencer
  wire seq_idle = (st_q == acomm_pkg::ACOMM_IDLE);
  a_irq_level: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_int_req == seq_idle)
      && (o_int_level == (seq_idle ? `ACOMM_INT_LEVEL : `ACOMM_INT_NONE)))
    else $error("Interrupt does not follow not-busy");
  a_reload: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_clk_en && !abort && st_q == acomm_pkg::ACOMM_WCTS && i_cts)
      |=> (o_mem_addr == $past(i_start_addr)))
    else $error("Current address not reloaded");
endmodule
`default_nettype wire

// [tb/acomm_modem_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "acomm_params.svh"

// ----------------------------------------------------------------
// Data set with a loop-back plug on the control lines
// ----------------------------------------------------------------
module acomm_modem_model (
  input  wire logic i_clock,
  input  wire logic i_rts,
  input  wire logic i_dtr,
  input  wire logic i_sup_tx,
  input  wire logic i_break,
  input  wire logic i_txd,
  input  wire logic i_cts_hold,
  output logic      o_cts,
  output logic      o_ring,
  output logic      o_dsr,
  output logic      o_carrier,
  output logic      o_sup_rx,
  output logic      o_rx_stb,
  output logic [7:0] o_rx_byte
);
  logic [2:0] dly = 3'h0;
  logic [7:0] sh;

  // Grant only after a request, a few cycles late; the bench can withhold it
  always @(posedge i_clock) dly <= {dly[1:0], i_rts & ~i_cts_hold};
  assign o_cts = dly[2];

  // Plug wiring: each output flag comes back on one input flag
  assign o_ring    = i_break;
  assign o_dsr     = i_dtr;
  assign o_carrier = i_sup_tx;
  assign o_sup_rx  = i_rts;

  // Line receiver, samples mid-bit; a bad stop bit drops the character
  initial
  begin
    o_rx_stb  = 1'b0;
    o_rx_byte = 8'h00;
    forever
    begin
      @(negedge i_txd);
      repeat (`ACOMM_BIT_CYC / 2) @(posedge i_clock);
      if (i_txd === 1'b0)
      begin
        for (int k = 0; k < 8; k++)
        begin
          repeat (`ACOMM_BIT_CYC) @(posedge i_clock);
          sh[k] = i_txd;
        end
        repeat (`ACOMM_BIT_CYC) @(posedge i_clock);
        if (i_txd === 1'b1)
        begin
          o_rx_byte <= sh;
          o_rx_stb  <= 1'b1;
          @(posedge i_clock);
          o_rx_stb  <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL = 3'h0, INI = 3'h1, DCL = 3'h2, WOF = 3'h3;
  localparam logic [2:0] RDF = 3'h4, RDP = 3'h5, XMT = 3'h6;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        sel = 1'b0, init = 1'b0, device_clear_command = 1'b0, wofl = 1'b0;
  logic        rdf = 1'b0, rdp = 1'b0, xmt = 1'b0, hold = 1'b0, ack = 1'b0;
  logic        cen = 1'b1;
  logic [7:0]  addr = 8'h00, line_output_flags = 8'h00, tch = 8'h00, mdat = 8'h00;
  logic [15:0] sa = 16'h0000, ta = 16'h0000;
  logic [1:0]  wcnt = 2'h0;
  logic [7:0]  iod, rxb;
  logic [15:0] maddr;
  logic [2:0]  lvl;
  logic        mreq, rts, dtr, stx, brk, txd, irq, cts, ring, dsr, carr, srx, rxs;
  logic [7:0]  mem [256];
  logic [7:0]  rxq [$];
  int          bad_count = 0;
  int          comparisons = 0;

  always #4 i_clock = ~i_clock;

  acomm_tx_ctrl i_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(cen),
    .i_sel_strobe(sel), .i_io_addr(addr), .i_init(init),
    .i_device_clear_command(device_clear_command), .i_write_line_output_flags(wofl),
    .i_ofl_data(line_output_flags), .i_read_line_input_flags(rdf), .i_read_input_port(rdp),
    .o_io_data(iod), .i_transmit_command(xmt), .i_start_addr(sa),
    .i_term_addr(ta), .i_term_char(tch), .o_mem_req(mreq), .o_mem_addr(maddr),
    .i_mem_ack(ack), .i_mem_data(mdat), .i_ring(ring), .i_dsr(dsr),
    .i_carrier(carr), .i_sup_rx(srx), .i_cts(cts), .o_rts(rts), .o_dtr(dtr),
    .o_sup_tx(stx), .o_break(brk), .o_txd(txd), .o_int_req(irq),
    .o_int_level(lvl)
  );

  acomm_modem_model i_modem (
    .i_clock(i_clock), .i_rts(rts), .i_dtr(dtr), .i_sup_tx(stx),
    .i_break(brk), .i_txd(txd), .i_cts_hold(hold), .o_cts(cts),
    .o_ring(ring), .o_dsr(dsr), .o_carrier(carr), .o_sup_rx(srx),
    .o_rx_stb(rxs), .o_rx_byte(rxb)
  );

  // Buffer memory answers each fetch three cycles late, so the request must hold
  always @(posedge i_clock)
  begin
    if (mreq === 1'b1 && !ack && wcnt == 2'h2)
    begin
      ack  <= 1'b1;
      mdat <= mem[maddr[7:0]];
      wcnt <= 2'h0;
    end
    else
    begin
      ack <= 1'b0;
      if (mreq === 1'b1 && !ack)
        wcnt <= wcnt + 2'h1;
    end
    if (rxs === 1'b1)
      rxq.push_back(rxb);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One-cycle command pulse; the edge after it has taken the command
  task automatic cmd(input logic [2:0] op, input logic [7:0] d);
    @(posedge i_clock);
    case (op)
      SEL: {sel, addr} <= {1'b1, d};
      INI: init <= 1'b1;
      DCL: device_clear_command <= 1'b1;
      WOF: {wofl, line_output_flags} <= {1'b1, d};
      RDF: rdf <= 1'b1;
      RDP: rdp <= 1'b1;
      default: xmt <= 1'b1;
    endcase
    @(posedge i_clock);
    {sel, init, device_clear_command, wofl, rdf, rdp, xmt} <= 7'h00;
    #1;
  endtask

  task automatic rd(input logic [7:0] e);
    cmd(RDF, 8'h00);
    chk({8'h00, iod}, {8'h00, e});
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 4000)
    begin
      @(posedge i_clock);
      k++;
    end
    repeat (4) @(posedge i_clock);
    #1;
    if (k == 4000)
    begin
      bad_count++;
      $display("[ERR] %0t transmit never finished", $time);
      finish_test();
    end
  endtask

  task automatic run_tx(input logic [15:0] s, input logic [15:0] t, input logic [7:0] c);
    @(posedge i_clock);
    {sa, ta, tch} <= {s, t, c};
    rxq.delete();
    cmd(XMT, 8'h00);
  endtask

  task automatic chk_rx(input int n, input logic [7:0] b);
    chk(16'(rxq.size()), 16'(n));
    for (int i = 0; i < n; i++)
      chk({8'h00, rxq[i]}, {8'h00, mem[b + 8'(i)]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_select;
    logic [7:0] nos [5] = '{8'h68, 8'h61, 8'h49, 8'h29, 8'h00};
    chk({13'h0, lvl}, 16'h0006);
    foreach (nos[i])
    begin
      cmd(SEL, nos[i]);
      rd(8'hff);
    end
    cmd(RDP, 8'h00);
    chk({8'h00, iod}, 16'h00ff);
    cmd(SEL, 8'h69);
    rd(8'h40);
    cmd(RDP, 8'h00);
    chk({8'h00, iod}, 16'h0000);
    cmd(INI, 8'h00);
    rd(8'hff);
    cmd(SEL, 8'hff);
    rd(8'h40);
    $display("select test done");
  endtask

  task automatic t_flags;
    int map [4] = '{3, 1, 2, 0};
    for (int b = 0; b < 4; b++)
    begin
      cmd(WOF, 8'h01 << b);
      chk({12'h0, brk, stx, dtr, rts}, 16'h0001 << b);
      rd(8'h40 | (8'h01 << map[b]));
    end
    cmd(WOF, 8'h0f);
    cmd(DCL, 8'h00);
    rd(8'h4f);
    cmd(INI, 8'h00);
    chk({12'h0, brk, stx, dtr, rts}, 16'h0000);
    cmd(SEL, 8'h69);
    cmd(DCL, 8'h00);
    chk({15'h0, txd}, 16'h0001);
    rd(8'h40);
    // Clock enable low freezes all state, so this flag write must be lost
    @(posedge i_clock);
    cen <= 1'b0;
    cmd(WOF, 8'h0f);
    chk({12'h0, brk, stx, dtr, rts}, 16'h0000);
    @(posedge i_clock);
    cen <= 1'b1;
    $display("flag test done");
  endtask

  task automatic t_transmit;
    hold <= 1'b1;
    run_tx(16'h0010, 16'h0013, mem[8'h40]);
    chk({13'h0, rts, irq, lvl == 3'h0}, 16'h0005);
    rd(8'h08);
    repeat (60) @(posedge i_clock);
    chk({14'h0, mreq, txd}, 16'h0001);
    hold <= 1'b0;
    wait_idle();
    chk_rx(4, 8'h10);
    chk(maddr, 16'h0013);
    chk({12'h0, rts, irq, lvl[2:1]}, 16'h0007);
    rd(8'h40);
    run_tx(16'h0020, 16'h002f, mem[8'h22]);
    wait_idle();
    chk_rx(3, 8'h20);
    chk(maddr, 16'h0022);
    $display("transmit test done");
  endtask

  task automatic t_abort;
    logic [2:0] ops [2] = '{DCL, INI};
    foreach (ops[i])
    begin
      cmd(SEL, 8'h69);
      run_tx(16'h0030, 16'h003f, mem[8'h40]);
      repeat (100) @(posedge i_clock);
      cmd(ops[i], 8'h00);
      chk({12'h0, rts, irq, txd, lvl[2]}, 16'h0007);
      repeat (200) @(posedge i_clock);
      chk({14'h0, mreq, txd}, 16'h0001);
    end
    $display("abort test done");
  endtask

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_select();
    t_flags();
    t_transmit();
    t_abort();
    finish_test();
  end
endmodule
`default_nettype wire
